// [include/pll_scan_pkg.sv]
// shared constants for the loop scan-chain reconfiguration ends
package pll_scan_pkg;
	localparam int CHAIN_BITS = 144;
	localparam int GROUP_BITS = 18;
	localparam int NUM_GROUPS = 7;
	localparam int COUNT_BITS = 8;
	localparam int PUMP_BITS = 9;
	localparam int FILTER_BITS = 9;
	localparam int PUMP_LSB = 0;
	localparam int PUMP_W = 3;
	localparam int RES_LSB = 0;
	localparam int RES_W = 5;
	localparam int CAP_LSB = 5;
	localparam int CAP_W = 2;
	localparam int PUMP_BASE = NUM_GROUPS * GROUP_BITS;
	localparam int FILTER_BASE = PUMP_BASE + PUMP_BITS;
	localparam int LOW_LSB = 0;
	localparam int ODD_POS = 8;
	localparam int HIGH_LSB = 9;
	localparam int BYPASS_POS = 17;
	localparam int SCAN_TOP_MHZ = 100;
	localparam int CLK_MHZ = 100;
	localparam int SCAN_DIV = (CLK_MHZ + SCAN_TOP_MHZ - 1) / SCAN_TOP_MHZ;
	localparam int UPDATE_TIME = 2;
	localparam int CNT_W = 8;
	localparam logic [CHAIN_BITS-1:0] CHAIN_RESET = {CHAIN_BITS{1'b0}};
	localparam logic [7:0] ZERO8 = 8'h00;
	localparam logic [7:0] LAST_BIT = 8'h8F;
	localparam logic [7:0] UPDATE_CYC = 8'h02;
	localparam logic [3:0] RESET_CYC = 4'h4;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_DATA0 = 8'h10;
	localparam logic [7:0] ADDR_DATA4 = 8'h20;
	localparam logic [7:0] ADDR_ACTIVE0 = 8'h30;
	localparam logic [7:0] ADDR_ACTIVE4 = 8'h40;
	localparam int CTRL_START = 0;
	localparam int CTRL_RESET = 1;
endpackage

// [include/pll_scan_if.sv]
// scan-chain link between reconfiguration controller and loop device
`timescale 1ns/10ps
`default_nettype none
interface pll_scan_if;
	logic shift_gate;
	logic scan_bit;
	logic apply_strobe;
	logic loop_reset;
	logic reconfig_done;
	modport device (input shift_gate, scan_bit, apply_strobe, loop_reset, output reconfig_done);
	modport ctrl (output shift_gate, scan_bit, apply_strobe, loop_reset, input reconfig_done);
endinterface
`default_nettype wire

// [rtl/pll_scan_device.sv]
// loop device end: 144-bit scan chain, active settings and divider outputs
`timescale 1ns/10ps
`default_nettype none
module pll_scan_device (
	input wire logic clk_in, // scan clock
	input wire logic nrst_in, // async reset, active low
	input wire logic vco_in, // oscillator clock
	input wire logic [2:0] tap_sel_in [pll_scan_pkg::NUM_GROUPS], // phase tap per group
	pll_scan_if.device link, // scan link
	output logic [pll_scan_pkg::NUM_GROUPS-1:0] div_clk_out, // divider outputs
	output logic [2:0] pump_current_code_out, // active pump code
	output logic [4:0] filter_resistor_code_out, // active resistor code
	output logic [1:0] filter_capacitor_code_out, // active capacitor code
	output logic [pll_scan_pkg::NUM_GROUPS-1:0] tap_out, // selected tap level per group
	output logic settings_valid_out // active codes are legal
);
	typedef struct packed {
		logic [pll_scan_pkg::CHAIN_BITS-1:0] chain;
		logic [pll_scan_pkg::CHAIN_BITS-1:0] active;
		logic gate_d;
		logic armed;
		logic [7:0] upd_cnt;
		logic done;
		logic [2:0] pump;
		logic [4:0] res;
		logic [1:0] cap;
		logic valid;
	} dev_state_t;
	dev_state_t st_reg, st_next;
	logic [7:0] vco_phases;
	logic [pll_scan_pkg::NUM_GROUPS-1:0] loaded;

	function automatic logic pump_ok(input logic [2:0] v);
		return v == 3'h0 || v == 3'h1 || v == 3'h3 || v == 3'h7;
	endfunction
	function automatic logic res_ok(input logic [4:0] v);
		case (v)
			5'h00, 5'h03, 5'h04, 5'h08, 5'h10, 5'h13, 5'h14, 5'h18, 5'h1B, 5'h1C, 5'h1E: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	always_comb begin
		st_next = st_reg;
		st_next.gate_d = link.shift_gate;
		st_next.armed = link.shift_gate && st_reg.gate_d;
		// shift toward LSB end, first bit lands at bit 0
		if (link.shift_gate && st_reg.gate_d)
			st_next.chain = {link.scan_bit, st_reg.chain[pll_scan_pkg::CHAIN_BITS-1:1]};
		if (link.apply_strobe && !link.shift_gate) begin
			st_next.active = st_reg.chain;
			st_next.upd_cnt = pll_scan_pkg::UPDATE_CYC;
			st_next.done = 1'b1;
		end else if (st_reg.upd_cnt != pll_scan_pkg::ZERO8) begin
			st_next.upd_cnt = st_reg.upd_cnt - 8'h01;
		end else if (&loaded) begin
			// fall once all dividers took new values
			st_next.done = 1'b0;
		end
		// pump and filter fields above the seven groups
		st_next.pump = st_reg.active[pll_scan_pkg::PUMP_BASE + pll_scan_pkg::PUMP_LSB
			+: pll_scan_pkg::PUMP_W];
		st_next.res = st_reg.active[pll_scan_pkg::FILTER_BASE + pll_scan_pkg::RES_LSB
			+: pll_scan_pkg::RES_W];
		st_next.cap = st_reg.active[pll_scan_pkg::FILTER_BASE + pll_scan_pkg::CAP_LSB
			+: pll_scan_pkg::CAP_W];
		st_next.valid = pump_ok(st_next.pump) && res_ok(st_next.res) && st_next.cap != 2'h2;
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// eight phase taps from a ring of delayed oscillator samples
	always_ff @(posedge vco_in or negedge nrst_in) begin
		if (!nrst_in) begin
			vco_phases <= 8'h0F;
		end else begin
			vco_phases <= {vco_phases[6:0], ~vco_phases[7]};
		end
	end

	genvar g;
	generate
		for (g = 0; g < pll_scan_pkg::NUM_GROUPS; g++) begin : gen_div
			// every divider on the shared oscillator clock
			pll_divider u_div (
				.vco_in(vco_in),
				.nrst_in(nrst_in),
				.setting_in(st_reg.active[g*pll_scan_pkg::GROUP_BITS +: pll_scan_pkg::GROUP_BITS]),
				.update_in(st_reg.done),
				.loaded_out(loaded[g]),
				.div_out(div_clk_out[g])
			);
			always_ff @(posedge clk_in or negedge nrst_in) begin
				if (!nrst_in) begin
					tap_out[g] <= 1'b0;
				end else begin
					tap_out[g] <= vco_phases[tap_sel_in[g]];
				end
			end
		end
	endgenerate

	always_comb begin
		link.reconfig_done = st_reg.done;
		pump_current_code_out = st_reg.pump;
		filter_resistor_code_out = st_reg.res;
		filter_capacitor_code_out = st_reg.cap;
		settings_valid_out = st_reg.valid;
	end
endmodule

// one 18-bit divider group, running on the oscillator
module pll_divider (
	input wire logic vco_in, // oscillator
	input wire logic nrst_in, // async reset, active low
	input wire logic [17:0] setting_in, // active group bits
	input wire logic update_in, // update window
	output logic loaded_out, // new setting taken
	output logic div_out // divided clock
);
	logic [17:0] cfg;
	logic [7:0] cnt;
	logic high, odd_cut, u1, u2;
	always_ff @(posedge vco_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cfg <= 18'h00000;
			cnt <= 8'h00;
			high <= 1'b0;
			u1 <= 1'b0;
			u2 <= 1'b0;
			loaded_out <= 1'b0;
		end else begin
			u1 <= update_in;
			u2 <= u1;
			loaded_out <= u2;
			if (u2 && !loaded_out) cfg <= setting_in;
			if (cfg[pll_scan_pkg::BYPASS_POS]) begin
				high <= ~high;
				cnt <= 8'h00;
			end else if (cnt <= 8'h01) begin
				high <= ~high;
				cnt <= high ? cfg[pll_scan_pkg::LOW_LSB +: 8] : cfg[pll_scan_pkg::HIGH_LSB +: 8];
			end else begin
				cnt <= cnt - 8'h01;
			end
		end
	end
	// odd duty ends high half a cycle early
	always_ff @(negedge vco_in or negedge nrst_in) begin
		if (!nrst_in) begin
			odd_cut <= 1'b0;
		end else begin
			odd_cut <= cfg[pll_scan_pkg::ODD_POS] && high && cnt <= 8'h01
				&& !cfg[pll_scan_pkg::BYPASS_POS];
		end
	end
	// bypass passes the oscillator straight through
	always_comb div_out = cfg[pll_scan_pkg::BYPASS_POS] ? vco_in : (high && !odd_cut);
endmodule
`default_nettype wire

// [rtl/pll_scan_ctrl.sv]
// controller end: register port, shifts a 144-bit load and applies it
`timescale 1ns/10ps
`default_nettype none
module pll_scan_ctrl (
	input wire logic clk_in, // clock, 100 MHz
	input wire logic nrst_in, // async reset, active low
	input wire logic [7:0] addr_in, // register address
	input wire logic [31:0] wdata_in, // write data
	input wire logic wr_in, // write strobe
	input wire logic rd_in, // read strobe
	output logic [31:0] rdata_out, // read data, next cycle
	pll_scan_if.ctrl link // scan link
);
	typedef enum logic [5:0] {
		S_IDLE = 6'b000001,
		S_GATE = 6'b000010,
		S_SHIFT = 6'b000100,
		S_APPLY = 6'b001000,
		S_WAIT = 6'b010000,
		S_RESET = 6'b100000
	} ctrl_state_t;
	typedef struct packed {
		ctrl_state_t st;
		logic [159:0] data;
		logic [7:0] idx;
		logic [3:0] rcnt;
		logic do_reset;
		logic gate;
		logic bit_o;
		logic strobe;
		logic areset;
		logic seen_done;
		logic [31:0] rdata;
	} ctrl_t;
	ctrl_t s_reg, s_next;
	always_comb begin
		s_next = s_reg;
		s_next.rdata = 32'h00000000;
		s_next.strobe = 1'b0;
		case (s_reg.st)
			S_IDLE: begin
				if (wr_in && addr_in == pll_scan_pkg::ADDR_CTRL && wdata_in[pll_scan_pkg::CTRL_START]) begin
					s_next.do_reset = wdata_in[pll_scan_pkg::CTRL_RESET];
					s_next.gate = 1'b1;
					s_next.idx = pll_scan_pkg::ZERO8;
					s_next.st = S_GATE;
				end
			end
			S_GATE: begin
				s_next.bit_o = s_reg.data[0];
				s_next.st = S_SHIFT;
			end
			// one bit a clock, gate drops after last
			S_SHIFT: begin
				if (s_reg.idx == pll_scan_pkg::LAST_BIT) begin
					s_next.gate = 1'b0;
					s_next.st = S_APPLY;
				end else begin
					s_next.idx = s_reg.idx + 8'h01;
					s_next.bit_o = s_reg.data[s_reg.idx + 8'h01];
				end
			end
			S_APPLY: begin
				s_next.strobe = 1'b1;
				s_next.seen_done = 1'b0;
				s_next.st = S_WAIT;
			end
			S_WAIT: begin
				if (link.reconfig_done) s_next.seen_done = 1'b1;
				if (s_reg.seen_done && !link.reconfig_done) begin
					s_next.rcnt = pll_scan_pkg::RESET_CYC;
					s_next.areset = s_reg.do_reset;
					s_next.st = s_reg.do_reset ? S_RESET : S_IDLE;
				end
			end
			S_RESET: begin
				if (s_reg.rcnt == 4'h1) begin
					s_next.areset = 1'b0;
					s_next.st = S_IDLE;
				end
				s_next.rcnt = s_reg.rcnt - 4'h1;
			end
			default: s_next.st = S_IDLE;
		endcase
		if (wr_in && s_reg.st == S_IDLE && addr_in >= pll_scan_pkg::ADDR_DATA0
			&& addr_in <= pll_scan_pkg::ADDR_DATA4 && addr_in[1:0] == 2'h0)
			s_next.data[32*((addr_in - pll_scan_pkg::ADDR_DATA0) >> 2) +: 32] = wdata_in;
		if (rd_in) begin
			if (addr_in == pll_scan_pkg::ADDR_STATUS)
				s_next.rdata = {26'h0000000, s_reg.st == S_IDLE, link.reconfig_done,
					s_reg.areset, s_reg.strobe, s_reg.gate, s_reg.do_reset};
			else if (addr_in >= pll_scan_pkg::ADDR_DATA0 && addr_in <= pll_scan_pkg::ADDR_DATA4
				&& addr_in[1:0] == 2'h0)
				s_next.rdata = s_reg.data[32*((addr_in - pll_scan_pkg::ADDR_DATA0) >> 2) +: 32];
		end
	end
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			s_reg <= '0;
			s_reg.st <= S_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end
	always_comb begin
		link.shift_gate = s_reg.gate;
		link.scan_bit = s_reg.bit_o;
		link.apply_strobe = s_reg.strobe;
		link.loop_reset = s_reg.areset;
		rdata_out = s_reg.rdata;
	end
endmodule
`default_nettype wire

// [testbench/pll_scan_assertions.sv]
// scan-link protocol checker for the controller and device pair
`timescale 1ns/10ps
`default_nettype none
module pll_scan_assertions (
	input wire logic clk_in, // clock
	input wire logic nrst_in, // async reset, active low
	input wire logic shift_gate, // gate
	input wire logic scan_bit, // serial bit
	input wire logic apply_strobe, // apply strobe
	input wire logic loop_reset, // loop reset
	input wire logic reconfig_done // done flag
);
	logic [7:0] gate_cnt_reg;
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) gate_cnt_reg <= 8'h00;
		else if (shift_gate) gate_cnt_reg <= gate_cnt_reg + 8'h01;
		else gate_cnt_reg <= 8'h00;
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	sequence s_strobe_pulse;
		apply_strobe ##1 !apply_strobe;
	endsequence
	sequence s_reset_pulse;
		loop_reset [*4] ##1 !loop_reset;
	endsequence
	a_gate_span: assert property ($fell(shift_gate) |-> gate_cnt_reg == 8'h91)
		else $error("gate not high for lead cycle plus 144 bits");
	a_gate_limit: assert property (gate_cnt_reg <= 8'h91)
		else $error("gate held past 144 bits");
	a_strobe_follows: assert property ($fell(shift_gate) |-> ##[1:2] s_strobe_pulse)
		else $error("no single apply pulse after gate fell");
	a_strobe_single: assert property ($rose(apply_strobe) |-> s_strobe_pulse)
		else $error("apply strobe wider than one cycle");
	a_no_strobe_shift: assert property (shift_gate |-> !apply_strobe)
		else $error("apply strobe during shifting");
	a_done_rises: assert property ($rose(apply_strobe) |-> ##[1:3] reconfig_done)
		else $error("done flag did not rise after apply");
	a_done_bounded: assert property ($rose(reconfig_done) |-> ##[1:300] !reconfig_done)
		else $error("done flag never fell");
	a_reset_len: assert property ($rose(loop_reset) |-> s_reset_pulse)
		else $error("loop reset not four cycles");
	a_reset_after: assert property ($rose(loop_reset) |-> !reconfig_done && !shift_gate)
		else $error("loop reset before update finished");
endmodule
`default_nettype wire

// [testbench/pll_scan_chain_reconfig_tb.sv]
// self-checking bench for the scan controller and loop device pair
`timescale 1ns/10ps
`default_nettype none
module pll_scan_chain_reconfig_tb;
	logic clk_in = 1'b0;
	logic vco = 1'b0;
	logic nrst_in = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic [2:0] tap_sel [pll_scan_pkg::NUM_GROUPS] = '{default: 3'h0};
	logic [6:0] div_clk;
	logic [6:0] taps;
	logic [2:0] pump;
	logic [4:0] res;
	logic [1:0] cap;
	logic valid;
	logic [143:0] seen;
	logic [7:0] gcnt = 8'h00;
	int mismatches = 0;
	int n_compared = 0;
	pll_scan_if link ();
	pll_scan_ctrl u_pll_scan_ctrl (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr),
		.wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .link(link));
	pll_scan_device u_pll_scan_device (.clk_in(clk_in), .nrst_in(nrst_in), .vco_in(vco),
		.tap_sel_in(tap_sel), .link(link), .div_clk_out(div_clk), .pump_current_code_out(pump),
		.filter_resistor_code_out(res), .filter_capacitor_code_out(cap), .tap_out(taps),
		.settings_valid_out(valid));
	pll_scan_assertions u_pll_scan_assertions (.clk_in(clk_in), .nrst_in(nrst_in),
		.shift_gate(link.shift_gate), .scan_bit(link.scan_bit), .apply_strobe(link.apply_strobe),
		.loop_reset(link.loop_reset), .reconfig_done(link.reconfig_done));
	always #5 clk_in = ~clk_in;
	always #1.25 vco = ~vco;
	// wire monitor: bits captured from second edge after gate
	always @(posedge clk_in) begin
		if (link.shift_gate) begin
			if (gcnt != 8'h00) seen[gcnt - 8'h01] = link.scan_bit;
			gcnt = gcnt + 8'h01;
		end else begin
			gcnt = 8'h00;
		end
	end
	task automatic check(input logic [143:0] got, input logic [143:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_in);
		wr <= 1'b0;
		@(posedge clk_in);
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_in);
		rd <= 1'b0;
		@(posedge clk_in);
		d = rdata;
	endtask
	task automatic load(input logic [2:0] p, input logic [4:0] r, input logic [1:0] c,
		input logic ok);
		logic [143:0] ch;
		logic [9:0] prev;
		logic [31:0] st;
		int n;
		ch = '0;
		for (int g = 0; g < pll_scan_pkg::NUM_GROUPS; g++) ch[18*g +: 18] = 18'h00201;
		ch[18 +: 18] = {1'b0, 8'h02, 1'b0, 8'h03};
		ch[36 +: 18] = {1'b0, 8'h02, 1'b1, 8'h01};
		ch[54 +: 18] = {1'b1, 8'h05, 1'b0, 8'h07};
		ch[126 + pll_scan_pkg::PUMP_LSB +: 3] = p;
		ch[135 + pll_scan_pkg::RES_LSB +: 5] = r;
		ch[135 + pll_scan_pkg::CAP_LSB +: 2] = c;
		for (n = 0; n < 5; n++) wr_reg(pll_scan_pkg::ADDR_DATA0 + 8'(4*n), 32'(ch >> (32*n)));
		prev = {pump, res, cap};
		wr_reg(pll_scan_pkg::ADDR_CTRL, {30'h00000000, ok, 1'b1});
		repeat (70) @(posedge clk_in);
		check(144'({pump, res, cap}), 144'(prev), "active codes moved while shifting");
		st = 32'h00000000;
		for (n = 0; n < 400 && st[5] !== 1'b1; n++) rd_reg(pll_scan_pkg::ADDR_STATUS, st);
		check(144'(st[5]), 144'h1, "load never finished");
		check(seen, ch, "chain bits on wire");
		check(144'({pump, res, cap}), 144'({p, r, c}), "codes not applied");
		check(144'(valid), 144'(ok), "code validity");
	endtask
	task meas(input int g, input int per, input int hi);
		realtime t0;
		realtime t1;
		@(posedge div_clk[g]);
		t0 = $realtime;
		@(negedge div_clk[g]);
		t1 = $realtime;
		@(posedge div_clk[g]);
		check(144'(int'((t1 - t0) * 100)), 144'(hi), "divider high time");
		check(144'(int'(($realtime - t0) * 100)), 144'(per), "divider period");
	endtask
	task automatic close_out();
		if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#200000;
		mismatches++;
		close_out();
	end
	initial begin
		logic [31:0] st;
		logic tap_prev;
		repeat (6) @(posedge clk_in);
		nrst_in <= 1'b1;
		@(posedge clk_in);
		load(3'h0, 5'h05, 2'h0, 1'b0);
		load(3'h2, 5'h00, 2'h2, 1'b0);
		load(3'h1, 5'h03, 2'h1, 1'b1);
		load(3'h3, 5'h13, 2'h0, 1'b1);
		load(3'h7, 5'h1E, 2'h3, 1'b1);
		tap_sel[1] <= 3'h4;
		repeat (2) @(posedge clk_in);
		tap_prev = taps[0];
		@(posedge clk_in);
		check(144'(taps[1]), 144'(tap_prev), "tap four not one clock behind tap zero");
		meas(1, 1250, 500);
		meas(2, 750, 375);
		meas(3, 250, 125);
		@(posedge clk_in);
		rd_reg(8'hFC, st);
		check(144'(st), 144'h0, "unmapped read not zero");
		close_out();
	end
endmodule
`default_nettype wire
